// ### hdl/rotate_left_unit.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_left_unit (
	input  wire logic [7:0] dst,
	input  wire logic       cin,
	input  wire logic       thru,
	output logic      [7:0] res,
	output logic            c,
	output logic            z,
	output logic            s,
	output logic            v
);
	always_comb
	begin
		// [RULE10] bit 7 into bit 0
		// [RULE12] old carry into bit 0
		res = {dst[6:0], thru ? cin : dst[7]};
		// [RULE13] carry from old msb
		c = dst[7];
		// [RULE14] zero result test
		z = (res == 8'h00);
		// [RULE15] sign from result
		s = res[7];
		// [RULE16] sign change overflow
		v = dst[7] ^ res[7];
	end
endmodule
`default_nettype wire

// ### hdl/stack_rotate_exec.sv
// Functional notes
// [RULE1] push first decrements stack pointer
// [RULE2] push stores source at new top
// [RULE3] clear carry only, six cycles
// [RULE4] return loads counter from stack
// [RULE5] return adds two to stack pointer
// [RULE6] high byte first, low byte next
// [RULE7] push and return keep flags
// [RULE8] high nibble E selects working register
// [RULE9] rotate left opcodes 90/91, six cycles
// [RULE10] rotate left wraps bit 7 around
// [RULE11] through-carry opcodes 10/11, six cycles
// [RULE12] through-carry: carry into bit 0
// [RULE13] carry equals original bit 7
// [RULE14] zero flag on zero result
// [RULE15] sign flag copies result bit 7
// [RULE16] overflow on sign change; D,H kept
// [RULE17] indirect mode reads pointer register
`timescale 1ns/1ps
`default_nettype none
module stack_rotate_exec #(
	parameter logic [4:0] EXIT_CYCLES = stack_rotate_pkg::CYC_SUB_EXIT
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             busy,
	output logic [15:0]      program_counter,
	output logic [7:0]       stack_top_pointer
);
	typedef struct packed {
		stack_rotate_pkg::fsm_t fsm;
		logic                   busy;
		logic [4:0]             cnt;
		logic [7:0]             op;
		logic [7:0]             opd;
		logic [7:0]             flags;
		logic [7:0]             stk;
		logic [15:0]            prog;
		logic [7:0]             rp;
		logic [7:0]             maddr;
		logic [255:0][7:0]      mem;
		logic                   done;
		logic                   ill;
		logic                   awready;
		logic                   wready;
		logic                   arready;
		logic                   aw_full;
		logic                   w_full;
		logic [7:0]             awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
	} state_t;

	state_t      q;
	state_t      d;
	logic [7:0]  wadr;
	logic [7:0]  ea;
	logic [7:0]  dst;
	logic        ind;
	logic        thru;
	logic [7:0]  rot_res;
	logic        rot_c;
	logic        rot_z;
	logic        rot_s;
	logic        rot_v;
	logic        commit;

	function automatic logic reg_hit(input logic [7:0] a);
		case (a)
			stack_rotate_pkg::A_CTRL,
			stack_rotate_pkg::A_STATUS,
			stack_rotate_pkg::A_FLAGS,
			stack_rotate_pkg::A_STACK,
			stack_rotate_pkg::A_COUNTER,
			stack_rotate_pkg::A_RPTR,
			stack_rotate_pkg::A_MADDR,
			stack_rotate_pkg::A_MDATA: reg_hit = 1'b1;
			default: reg_hit = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] rd_val(input state_t s,
		input logic [7:0] a);
		case (a)
			stack_rotate_pkg::A_CTRL:   rd_val = {16'h0000, s.opd, s.op};
			stack_rotate_pkg::A_STATUS: rd_val = {29'h0000_0000, s.ill,
				s.done, s.busy};
			stack_rotate_pkg::A_FLAGS:  rd_val = {24'h00_0000, s.flags};
			stack_rotate_pkg::A_STACK:   rd_val = {24'h00_0000, s.stk};
			stack_rotate_pkg::A_COUNTER: rd_val = {16'h0000, s.prog};
			stack_rotate_pkg::A_RPTR:   rd_val = {24'h00_0000, s.rp};
			stack_rotate_pkg::A_MADDR:  rd_val = {24'h00_0000, s.maddr};
			stack_rotate_pkg::A_MDATA:  rd_val = {24'h00_0000,
				s.mem[s.maddr]};
			default: rd_val = 32'h0000_0000;
		endcase
	endfunction

	// cycle count per opcode, zero when not supported
	function automatic logic [4:0] op_cycles(input logic [7:0] op);
		case (op)
			stack_rotate_pkg::OP_PUSH_DIRECT:
				op_cycles = stack_rotate_pkg::CYC_PUSH_DIRECT;
			stack_rotate_pkg::OP_PUSH_PTR:
				op_cycles = stack_rotate_pkg::CYC_PUSH_PTR;
			stack_rotate_pkg::OP_CLEAR_CARRY:
				op_cycles = stack_rotate_pkg::CYC_CLEAR_CARRY;
			stack_rotate_pkg::OP_SUB_EXIT: op_cycles = EXIT_CYCLES;
			stack_rotate_pkg::OP_ROT_DIRECT,
			stack_rotate_pkg::OP_ROT_PTR,
			stack_rotate_pkg::OP_ROTC_DIRECT,
			stack_rotate_pkg::OP_ROTC_PTR:
				op_cycles = stack_rotate_pkg::CYC_ROT;
			default: op_cycles = 5'h00;
		endcase
	endfunction

	// operand address decode
	always_comb
	begin
		// [RULE8] working register decode
		wadr = (q.opd[7:4] == stack_rotate_pkg::WREG_PFX)
			? {q.rp[7:4], q.opd[3:0]} : q.opd;
		ind = q.op[0];
		// [RULE17] pointer register indirection
		ea = ind ? q.mem[wadr] : wadr;
		dst = q.mem[ea];
		thru = (q.op == stack_rotate_pkg::OP_ROTC_DIRECT)
			|| (q.op == stack_rotate_pkg::OP_ROTC_PTR);
		commit = (q.fsm == stack_rotate_pkg::S_RUN) && (q.cnt == 5'h00);
	end

	rotate_left_unit u_rot (
		.dst  (dst),
		.cin  (q.flags[stack_rotate_pkg::F_C]),
		.thru (thru),
		.res  (rot_res),
		.c    (rot_c),
		.z    (rot_z),
		.s    (rot_s),
		.v    (rot_v)
	);

	always_comb
	begin
		logic [31:0] wv;
		logic [31:0] old;
		logic [4:0]  cyc;
		wv = 32'h0000_0000;
		old = 32'h0000_0000;
		cyc = 5'h00;
		d = q;
		// bus channel capture
		if (q.awready && awvalid)
		begin
			d.aw_full = 1'b1;
			d.awaddr = awaddr;
		end
		if (q.wready && wvalid)
		begin
			d.w_full = 1'b1;
			d.wdata = wdata;
			d.wstrb = wstrb;
		end
		if (q.bvalid && bready)
			d.bvalid = 1'b0;
		if (q.rvalid && rready)
			d.rvalid = 1'b0;
		// register write, byte lanes merged
		if (q.aw_full && q.w_full && !q.bvalid)
		begin
			d.aw_full = 1'b0;
			d.w_full = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = reg_hit(q.awaddr) ? stack_rotate_pkg::RESP_OKAY
				: stack_rotate_pkg::RESP_SLVERR;
			old = rd_val(q, q.awaddr);
			for (int i = 0; i < 4; i++)
				wv[i*8 +: 8] = q.wstrb[i] ? q.wdata[i*8 +: 8]
					: old[i*8 +: 8];
			if (q.awaddr == stack_rotate_pkg::A_STATUS)
			begin
				if (wv[stack_rotate_pkg::ST_DONE])
					d.done = 1'b0;
				if (wv[stack_rotate_pkg::ST_ILL])
					d.ill = 1'b0;
			end
			else if (!q.busy)
			begin
				case (q.awaddr)
					stack_rotate_pkg::A_CTRL:
					begin
						d.op = wv[7:0];
						d.opd = wv[15:8];
						cyc = op_cycles(wv[7:0]);
						if (cyc != 5'h00)
						begin
							d.fsm = stack_rotate_pkg::S_RUN;
							d.busy = 1'b1;
							d.cnt = cyc - 5'h01;
						end
						else
							d.ill = 1'b1;
					end
					stack_rotate_pkg::A_FLAGS: d.flags = wv[7:0];
					stack_rotate_pkg::A_STACK:   d.stk = wv[7:0];
					stack_rotate_pkg::A_COUNTER: d.prog = wv[15:0];
					stack_rotate_pkg::A_RPTR:  d.rp = wv[7:0];
					stack_rotate_pkg::A_MADDR: d.maddr = wv[7:0];
					stack_rotate_pkg::A_MDATA: d.mem[q.maddr] = wv[7:0];
					default: d.rp = q.rp;
				endcase
			end
		end
		// instruction execution
		if (q.fsm == stack_rotate_pkg::S_RUN)
		begin
			if (q.cnt != 5'h00)
				d.cnt = q.cnt - 5'h01;
			else
			begin
				d.fsm = stack_rotate_pkg::S_IDLE;
				d.busy = 1'b0;
				// done set wins over clear
				d.done = 1'b1;
				case (q.op)
					// [RULE7] flags untouched here
					stack_rotate_pkg::OP_PUSH_DIRECT,
					stack_rotate_pkg::OP_PUSH_PTR:
					begin
						// [RULE1] stack pointer decrement
						d.stk = q.stk - 8'h01;
						// [RULE2] store at new top
						d.mem[q.stk - 8'h01] = dst;
					end
					stack_rotate_pkg::OP_SUB_EXIT:
					begin
						// [RULE4] reload program counter
						// [RULE6] high then low byte
						d.prog = {q.mem[q.stk], q.mem[q.stk + 8'h01]};
						// [RULE5] stack pointer plus two
						d.stk = q.stk + 8'h02;
					end
					stack_rotate_pkg::OP_CLEAR_CARRY:
						// [RULE3] carry forced low
						d.flags[stack_rotate_pkg::F_C] = 1'b0;
					stack_rotate_pkg::OP_ROT_DIRECT,
					stack_rotate_pkg::OP_ROT_PTR,
					stack_rotate_pkg::OP_ROTC_DIRECT,
					stack_rotate_pkg::OP_ROTC_PTR:
					begin
						// [RULE9] [RULE11] rotate commit
						d.mem[ea] = rot_res;
						// [RULE13] [RULE14] rotate flag update
						d.flags[stack_rotate_pkg::F_C] = rot_c;
						d.flags[stack_rotate_pkg::F_Z] = rot_z;
						// [RULE15] [RULE16] sign and overflow
						d.flags[stack_rotate_pkg::F_S] = rot_s;
						d.flags[stack_rotate_pkg::F_V] = rot_v;
					end
					default: d.ill = 1'b1;
				endcase
			end
		end
		// read channel
		if (q.arready && arvalid)
		begin
			d.rvalid = 1'b1;
			d.rdata = rd_val(q, araddr);
			d.rresp = reg_hit(araddr) ? stack_rotate_pkg::RESP_OKAY
				: stack_rotate_pkg::RESP_SLVERR;
		end
		d.awready = !d.aw_full && !d.bvalid;
		d.wready = !d.w_full && !d.bvalid;
		d.arready = !d.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			q <= '0;
			q.stk <= stack_rotate_pkg::RST_STACK;
			q.prog <= stack_rotate_pkg::RST_COUNTER;
			q.flags <= stack_rotate_pkg::RST_FLAGS;
		end
		else
			q <= d;
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign bvalid = q.bvalid;
	assign bresp = q.bresp;
	assign arready = q.arready;
	assign rvalid = q.rvalid;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign busy = q.busy;
	assign program_counter = q.prog;
	assign stack_top_pointer = q.stk;

	// checks
	logic is_push;
	logic is_rot;
	assign is_push = (q.op == stack_rotate_pkg::OP_PUSH_DIRECT)
		|| (q.op == stack_rotate_pkg::OP_PUSH_PTR);
	assign is_rot = (q.op == stack_rotate_pkg::OP_ROT_DIRECT)
		|| (q.op == stack_rotate_pkg::OP_ROT_PTR) || thru;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_push_sp_dec: assert property (commit && is_push |=> // [RULE1]
		q.stk == $past(q.stk) - 8'h01)
		else $error("push did not decrement stack pointer");
	a_push_store: assert property (commit && is_push |=> // [RULE2]
		q.mem[q.stk] == $past(dst))
		else $error("push stored wrong byte");
	a_carry_clear: assert property (commit && q.op == // [RULE3]
		stack_rotate_pkg::OP_CLEAR_CARRY |=>
		!q.flags[stack_rotate_pkg::F_C]
		&& q.flags[6:0] == $past(q.flags[6:0]))
		else $error("clear carry wrong");
	a_exit_load: assert property (commit && q.op == // [RULE4]
		stack_rotate_pkg::OP_SUB_EXIT |=>
		q.prog == {$past(q.mem[q.stk]), $past(q.mem[q.stk + 8'h01])}
		&& q.stk == $past(q.stk) + 8'h02)
		else $error("return load wrong");
	a_stack_flags: assert property (commit && (is_push || // [RULE7]
		q.op == stack_rotate_pkg::OP_SUB_EXIT) |=> $stable(q.flags))
		else $error("stack op altered flags");
	a_wreg_decode: assert property (q.busy && // [RULE8]
		q.opd[7:4] == stack_rotate_pkg::WREG_PFX |-> wadr[3:0] ==
		q.opd[3:0] && wadr[7:4] == q.rp[7:4])
		else $error("working register decode wrong");
	a_rot_cycles: assert property ($rose(q.busy) && is_rot // [RULE9]
		|-> q.busy[*6] ##1 !q.busy)
		else $error("rotate did not take six cycles");
	a_rl_result: assert property (commit && is_rot && !thru // [RULE10]
		|=> q.mem[$past(ea)] == {$past(dst[6:0]), $past(dst[7])})
		else $error("rotate left result wrong");
	a_rlc_result: assert property (commit && thru |=> // [RULE12]
		q.mem[$past(ea)] == {$past(dst[6:0]),
		$past(q.flags[stack_rotate_pkg::F_C])})
		else $error("rotate through carry result wrong");
	a_rot_flags: assert property (commit && is_rot |=> // [RULE16]
		q.flags[7:2] == {$past(dst[7]), $past(rot_res) == 8'h00,
		$past(rot_res[7]), $past(dst[7] ^ rot_res[7]),
		$past(q.flags[3:2])})
		else $error("rotate flags wrong");
	a_ind_addr: assert property (q.busy && ind // [RULE17]
		|-> ea == q.mem[wadr])
		else $error("indirect address wrong");

	c_push: cover property (commit && is_push);
	c_exit: cover property (commit
		&& q.op == stack_rotate_pkg::OP_SUB_EXIT);
	c_rlc: cover property (commit && thru);
	c_ill: cover property ($rose(q.ill));
endmodule
`default_nettype wire

// ### hdl/stack_rotate_pkg.sv
package stack_rotate_pkg;
	// opcodes
	localparam logic [7:0] OP_PUSH_DIRECT = 8'h70;
	localparam logic [7:0] OP_PUSH_PTR    = 8'h71;
	localparam logic [7:0] OP_CLEAR_CARRY = 8'hCF;
	localparam logic [7:0] OP_SUB_EXIT    = 8'hAF;
	localparam logic [7:0] OP_ROT_DIRECT  = 8'h90;
	localparam logic [7:0] OP_ROT_PTR     = 8'h91;
	localparam logic [7:0] OP_ROTC_DIRECT = 8'h10;
	localparam logic [7:0] OP_ROTC_PTR    = 8'h11;
	// working register prefix in operand high nibble
	localparam logic [3:0] WREG_PFX    = 4'hE;
	// cycle counts per instruction
	localparam logic [4:0] CYC_ROT     = 5'h06;
	localparam logic [4:0] CYC_CLEAR_CARRY = 5'h06;
	localparam logic [4:0] CYC_PUSH_DIRECT = 5'h0A;
	localparam logic [4:0] CYC_PUSH_PTR    = 5'h0C;
	localparam logic [4:0] CYC_SUB_EXIT    = 5'h0E;
	// flag bit positions
	localparam int F_C = 7;
	localparam int F_Z = 6;
	localparam int F_S = 5;
	localparam int F_V = 4;
	localparam int F_D = 3;
	localparam int F_H = 2;
	// register byte offsets
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_FLAGS  = 8'h08;
	localparam logic [7:0] A_STACK   = 8'h0C;
	localparam logic [7:0] A_COUNTER = 8'h10;
	localparam logic [7:0] A_RPTR   = 8'h14;
	localparam logic [7:0] A_MADDR  = 8'h18;
	localparam logic [7:0] A_MDATA  = 8'h1C;
	// status bits
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ILL  = 2;
	// reset values
	localparam logic [7:0]  RST_STACK   = 8'h00;
	localparam logic [15:0] RST_COUNTER = 16'h0000;
	localparam logic [7:0]  RST_FLAGS = 8'h00;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic
	{
		S_IDLE = 1'b0,
		S_RUN  = 1'b1
	} fsm_t;
endpackage

// ### tb/stack_rotate_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stack_rotate_exec_tb;
	localparam logic [4:0] EXIT_N = 5'h09;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wvalid = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic [7:0]  araddr = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        busy;
	logic [15:0] prog_count;
	logic [7:0]  stack_top;
	logic [1:0]  bq[$];
	logic [33:0] rq[$];
	int          miscompares = 0;
	int          compares = 0;

	always #50 aclk = ~aclk;

	stack_rotate_exec #(.EXIT_CYCLES(EXIT_N)) stack_rotate_exec_i (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(1'b1),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
		.busy(busy), .program_counter(prog_count),
		.stack_top_pointer(stack_top)
	);

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= 200)
		begin
			miscompares++;
			finish_test();
		end
	endtask

	// response monitor
	always @(posedge aclk)
	begin
		if (aresetn && bvalid === 1'b1)
			chk({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
		if (aresetn && rvalid === 1'b1)
			chk({rresp, rdata}, rq.pop_front());
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = stack_rotate_pkg::RESP_OKAY);
		int n;
		bit ad;
		bit wd;
		n = 0;
		ad = 1'b0;
		wd = 1'b0;
		bq.push_back(er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd) && n < 200)
		begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1 && !ad)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !wd)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end
		tmo(n);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (bvalid !== 1'b1 && n < 200);
		tmo(n);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er = stack_rotate_pkg::RESP_OKAY);
		int n;
		n = 0;
		rq.push_back({er, ed});
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (arready !== 1'b1 && n < 200);
		arvalid <= 1'b0;
		tmo(n);
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rvalid !== 1'b1 && n < 200);
		tmo(n);
	endtask

	task automatic setm(input logic [7:0] a, input logic [7:0] v);
		wr(stack_rotate_pkg::A_MADDR, {24'h00_0000, a});
		wr(stack_rotate_pkg::A_MDATA, {24'h00_0000, v});
	endtask

	task automatic getm(input logic [7:0] a, input logic [7:0] v);
		wr(stack_rotate_pkg::A_MADDR, {24'h00_0000, a});
		rd(stack_rotate_pkg::A_MDATA, {24'h00_0000, v});
	endtask

	task automatic exec(input logic [7:0] op, input logic [7:0] opnd,
		input logic [4:0] cyc);
		int n;
		n = 1;
		wr(stack_rotate_pkg::A_CTRL, {16'h0000, opnd, op});
		while (n < 200)
		begin
			@(posedge aclk);
			if (busy !== 1'b1) break;
			n++;
		end
		tmo(n);
		chk(34'(n), {29'h0000_0000, cyc});
	endtask

	initial
	begin
		logic [7:0] ops[4];
		logic [7:0] op, v, f, ea, opnd, r, nf, x, y;
		ops = '{stack_rotate_pkg::OP_ROT_DIRECT,
			stack_rotate_pkg::OP_ROT_PTR,
			stack_rotate_pkg::OP_ROTC_DIRECT,
			stack_rotate_pkg::OP_ROTC_PTR};
		void'($urandom(15679));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({26'h0, stack_top}, {26'h0, stack_rotate_pkg::RST_STACK});
		rd(stack_rotate_pkg::A_FLAGS, 32'h0000_0000);
		rd(8'h40, 32'h0000_0000, stack_rotate_pkg::RESP_SLVERR);
		wr(8'h44, 32'h0000_00FF, stack_rotate_pkg::RESP_SLVERR);
		wr(stack_rotate_pkg::A_RPTR, 32'h0000_0030);
		for (int i = 0; i < 8; i++)
		begin
			op = ops[i % 4];
			v = 8'($urandom());
			f = 8'($urandom()) & 8'hFC;
			if (i == 2)
			begin
				v = 8'h80;
				f[7] = 1'b0;
			end
			ea = 8'h80 | 8'($urandom_range(63));
			opnd = (i < 4) ? 8'hE5 : 8'h4A;
			if (op[0])
				setm(8'h37, ea);
			if (op[0])
				opnd = 8'hE7;
			else
				ea = (i < 4) ? 8'h35 : 8'h4A;
			setm(ea, v);
			wr(stack_rotate_pkg::A_FLAGS, {24'h00_0000, f});
			r = op[7] ? {v[6:0], v[7]} : {v[6:0], f[7]};
			nf = f;
			nf[7] = v[7];
			nf[6] = (r == 8'h00);
			nf[5] = r[7];
			nf[4] = v[7] ^ r[7];
			exec(op, opnd, stack_rotate_pkg::CYC_ROT);
			getm(ea, r);
			rd(stack_rotate_pkg::A_FLAGS, {24'h00_0000, nf});
		end
		wr(stack_rotate_pkg::A_FLAGS, 32'h0000_00FC);
		exec(stack_rotate_pkg::OP_CLEAR_CARRY, 8'h00,
			stack_rotate_pkg::CYC_CLEAR_CARRY);
		rd(stack_rotate_pkg::A_FLAGS, 32'h0000_007C);
		x = 8'($urandom());
		y = 8'($urandom());
		f = 8'($urandom()) & 8'hFC;
		setm(8'h32, x);
		setm(8'h34, 8'h90);
		setm(8'h90, y);
		wr(stack_rotate_pkg::A_FLAGS, {24'h00_0000, f});
		exec(stack_rotate_pkg::OP_PUSH_DIRECT, 8'hE2,
			stack_rotate_pkg::CYC_PUSH_DIRECT);
		chk({26'h0, stack_top}, {26'h0, 8'hFF});
		getm(8'hFF, x);
		exec(stack_rotate_pkg::OP_PUSH_PTR, 8'hE4,
			stack_rotate_pkg::CYC_PUSH_PTR);
		chk({26'h0, stack_top}, {26'h0, 8'hFE});
		getm(8'hFE, y);
		exec(stack_rotate_pkg::OP_SUB_EXIT, 8'h00, EXIT_N);
		chk({18'h0, prog_count}, {18'h0, y, x});
		chk({26'h0, stack_top}, {26'h0, 8'h00});
		rd(stack_rotate_pkg::A_COUNTER, {16'h0000, y, x});
		rd(stack_rotate_pkg::A_FLAGS, {24'h00_0000, f});
		// status: done after exit, unsupported opcode, clear
		rd(stack_rotate_pkg::A_STATUS, 32'h0000_0002);
		wr(stack_rotate_pkg::A_CTRL, 32'h0000_00FF);
		rd(stack_rotate_pkg::A_STATUS, 32'h0000_0006);
		wr(stack_rotate_pkg::A_STATUS, 32'h0000_0006);
		rd(stack_rotate_pkg::A_STATUS, 32'h0000_0000);
		finish_test();
	end
endmodule
`default_nettype wire
